// [smsw_pkg.sv]
// constants, types and helpers of the subclock mode and stop wakeup block
// assumes a single system clock domain and a 32-bit Avalon-MM register port
`default_nettype none

package smsw_pkg;

   // ************************************************
   // timing
   // ************************************************
   localparam int unsigned SYS_CLK_FREQ_HZ  = 200_000_000;
   localparam int unsigned MAIN_OSC_FREQ_HZ = 4_000_000;
   localparam logic [3:0]  SWITCH_GAP_CYC   = 4'h2;

   // ************************************************
   // register map
   // ************************************************
   localparam logic [3:0] CLK_CTRL_OFS = 4'h0;
   localparam logic [3:0] STAB_SEL_OFS = 4'h4;
   localparam logic [3:0] PCFG_OFS     = 4'h8;
   localparam logic [3:0] STATUS_OFS   = 4'hc;

   localparam int DIV_LSB       = 0;
   localparam int DIV_MSB       = 2;
   localparam int SUBSEL_POS    = 3;
   localparam int MOSC_STOP_POS = 6;
   localparam int STAB_SEL_W    = 3;

   localparam int ST_ON_SUB_POS  = 0;
   localparam int ST_ON_MAIN_POS = 1;
   localparam int ST_STAB_POS    = 2;
   localparam int ST_MOSC_POS    = 3;
   localparam int ST_CPU_POS     = 4;

   localparam logic [2:0] DIV_RST      = 3'h3;
   localparam logic [2:0] STAB_SEL_RST = 3'h2;
   localparam logic [4:0] STAB_EXP_BASE = 5'hd;
   localparam logic [4:0] STAB_SEL_MAX  = 5'h4;

   // ************************************************
   // types
   // ************************************************
   typedef enum logic [1:0] {PS_RUN, PS_STOP, PS_WAKE} smsw_pwr_t;
   typedef enum logic [1:0] {CS_MAIN, CS_TO_SUB, CS_SUB, CS_TO_MAIN} smsw_csw_t;

   // count-clock choices of the peripherals
   typedef struct packed {
      logic       tm16b_watch;
      logic       watch_sub;
      logic [1:0] tm8_ext;
      logic [1:0] tm8_cmp;
      logic       itmr2_sub;
      logic       wdog2_sub;
      logic [1:0] csi_ext;
      logic       async_ext;
      logic       rto_tm8;
      logic       rto_tm8_sel;
   } smsw_pcfg_t;

   // peripheral clock enables
   typedef struct packed {
      logic       tm16a;
      logic       tm16b;
      logic [1:0] tm8;
      logic       itmr2;
      logic       watch;
      logic       wdog2;
      logic [1:0] csi;
      logic       async_port;
      logic       rto;
   } smsw_pen_t;

   localparam int PCFG_W = $bits(smsw_pcfg_t);

   // ************************************************
   // helpers
   // ************************************************
   function automatic logic [31:0] stab_cycles(input logic [2:0] sel, input logic [31:0] per_main);
      logic [4:0] ex;
      ex = STAB_EXP_BASE + ((5'(sel) > STAB_SEL_MAX) ? STAB_SEL_MAX : 5'(sel));
      return per_main << ex;
   endfunction

   function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) r[8*i +: 8] = wd[8*i +: 8];
      end
      return r;
   endfunction

endpackage

`default_nettype wire

// [smsw_stab_timer.sv]
// oscillation stabilization down-counter
// assumes load and cycle count come from logic on the same clock
`default_nettype none

module smsw_stab_timer import smsw_pkg::*; #(
   parameter logic [31:0] RST_CYCLES = 32'h0000_0010
) (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        en_i,
   // control
   input  wire logic        load_i,
   input  wire logic [31:0] cycles_i,
   output logic             busy_o
);

   logic [31:0] cnt_q;

   // reset counts as a stop release, so the wait starts at once
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_q <= RST_CYCLES;
      end else if (en_i) begin
         if (load_i) begin
            cnt_q <= cycles_i;
         end else if (cnt_q != 32'h0) begin
            cnt_q <= cnt_q - 32'h1;
         end
      end
   end

   assign busy_o = (cnt_q != 32'h0);

endmodule // smsw_stab_timer

`default_nettype wire

// [smsw_clk_switch.sv]
// break-before-make selector between main clock and subclock
// assumes the selects drive a clock gate that switches only when its clock is low
`default_nettype none

module smsw_clk_switch import smsw_pkg::*; #(
   parameter logic [3:0] GAP = SWITCH_GAP_CYC
) (
   // clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic en_i,
   // request
   input  wire logic want_sub_i,
   input  wire logic main_ok_i,
   // selects
   output logic      sel_main_o,
   output logic      sel_sub_o
);

   smsw_csw_t  st_q;
   logic [3:0] gap_q;

   // both sources off for a few cycles so no runt pulse reaches the tree
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         st_q  <= CS_MAIN;
         gap_q <= 4'h0;
      end else if (en_i) begin
         unique case (st_q)
            CS_MAIN: begin
               if (want_sub_i) begin
                  st_q  <= CS_TO_SUB;
                  gap_q <= GAP;
               end
            end
            CS_TO_SUB: begin
               if (gap_q == 4'h0) st_q <= CS_SUB;
               else gap_q <= 4'(gap_q - 4'h1);
            end
            CS_SUB: begin
               // never fall back onto a stopped main oscillator
               if (!want_sub_i && main_ok_i) begin
                  st_q  <= CS_TO_MAIN;
                  gap_q <= GAP;
               end
            end
            CS_TO_MAIN: begin
               if (gap_q == 4'h0) st_q <= CS_MAIN;
               else gap_q <= 4'(gap_q - 4'h1);
            end
         endcase
      end
   end

   assign sel_main_o = (st_q == CS_MAIN);
   assign sel_sub_o  = (st_q == CS_SUB);

   // ************************************************
   // assertions
   // ************************************************
   property p_sw_gap;
      @(posedge clk_i) disable iff (rst_i)
      $fell(sel_main_o) |-> !sel_sub_o [*2];
   endproperty
   a_sw_gap: assert property (p_sw_gap) else $error("subclock selected right after main");

endmodule // smsw_clk_switch

`default_nettype wire

// [smsw_top.sv]
// subclock mode and stop wakeup clock control, top level
// assumes stop request, wake interrupt and watchdog resets come from logic on SYS_CLK_I
//
// Our own choices: the register offsets and the Avalon-MM slave port.
`default_nettype none

module smsw_top import smsw_pkg::*; #(
   parameter logic [31:0] CYC_PER_MAIN = 32'(SYS_CLK_FREQ_HZ / MAIN_OSC_FREQ_HZ),
   parameter logic [3:0]  SWITCH_GAP   = SWITCH_GAP_CYC
) (
   // clock, reset, enable
   input  wire logic        SYS_CLK_I,
   input  wire logic        RESET_I,
   input  wire logic        CLK_EN_I,
   // avalon-mm slave
   input  wire logic [3:0]  AVS_ADDRESS_I,
   input  wire logic        AVS_READ_I,
   input  wire logic        AVS_WRITE_I,
   input  wire logic [31:0] AVS_WRITEDATA_I,
   input  wire logic [3:0]  AVS_BYTEENABLE_I,
   output logic [31:0]      AVS_READDATA_O,
   output logic             AVS_WAITREQUEST_O,
   // system events
   input  wire logic        WDOG1_RESET_I,
   input  wire logic        WDOG2_RESET_I,
   input  wire logic        STOP_REQ_I,
   input  wire logic        WAKE_IRQ_I,
   // clock control
   output logic             MAIN_OSC_EN_O,
   output logic             SYS_CLK_SEL_MAIN_O,
   output logic             SYS_CLK_SEL_SUB_O,
   output logic             CPU_CLK_EN_O,
   output logic [2:0]       DIVIDER_SEL_O,
   output smsw_pen_t        PERIPH_CLK_EN_O
);

   localparam logic [31:0] RST_STAB = stab_cycles(STAB_SEL_RST, CYC_PER_MAIN);

   smsw_pwr_t   state_q;
   logic [2:0]  div_q;
   logic        subsel_q;
   logic        mosc_q;
   logic [2:0]  stab_sel_q;
   smsw_pcfg_t  pcfg_q;
   logic        ack_q;
   logic [31:0] rdata_q;
   logic [31:0] rd_d;
   logic        acc;
   logic        do_wr;
   logic        sync_rst;
   logic        busy;
   logic        stab_load;
   logic [31:0] stab_len;
   logic        on_main;
   logic        on_sub;
   logic        mosc_en_d;
   logic        mosc_en_q;
   logic        main_run;
   smsw_pen_t   pen_d;
   smsw_pen_t   pen_q;
   logic [7:0]  ctl_img;
   logic [7:0]  stat_img;
   logic [31:0] ctl_w;
   logic [31:0] sel_w;
   logic [31:0] cfg_w;

   assign sync_rst = WDOG1_RESET_I | WDOG2_RESET_I;

   // ************************************************
   // avalon slave
   // ************************************************
   // one wait state on every access; answer comes on the second edge
   assign acc               = AVS_READ_I | AVS_WRITE_I;
   assign AVS_WAITREQUEST_O = acc & ~ack_q;
   assign do_wr             = AVS_WRITE_I & ack_q;
   assign AVS_READDATA_O    = rdata_q;

   always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         ack_q <= 1'b0;
      end else if (CLK_EN_I) begin
         ack_q <= acc & ~ack_q;
      end
   end

   always_comb begin
      ctl_img                  = 8'h00;
      ctl_img[DIV_MSB:DIV_LSB] = div_q;
      ctl_img[SUBSEL_POS]      = subsel_q;
      ctl_img[MOSC_STOP_POS]   = mosc_q;
   end

   always_comb begin
      stat_img                 = 8'h00;
      stat_img[ST_ON_SUB_POS]  = on_sub;
      stat_img[ST_ON_MAIN_POS] = on_main;
      stat_img[ST_STAB_POS]    = busy;
      stat_img[ST_MOSC_POS]    = mosc_en_q;
      stat_img[ST_CPU_POS]     = CPU_CLK_EN_O;
   end

   always_comb begin
      unique case (AVS_ADDRESS_I)
         CLK_CTRL_OFS: rd_d = 32'(ctl_img);
         STAB_SEL_OFS: rd_d = 32'(stab_sel_q);
         PCFG_OFS:     rd_d = 32'(pcfg_q);
         STATUS_OFS:   rd_d = 32'(stat_img);
         // unmapped offsets read zero, writes are dropped
         default:      rd_d = 32'h0;
      endcase
   end

   always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         rdata_q <= 32'h0;
      end else if (CLK_EN_I && AVS_READ_I && !ack_q) begin
         rdata_q <= rd_d;
      end
   end

   // ************************************************
   // control registers
   // ************************************************
   assign ctl_w = be_merge(32'(ctl_img), AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
   assign sel_w = be_merge(32'(stab_sel_q), AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
   assign cfg_w = be_merge(32'(pcfg_q), AVS_WRITEDATA_I, AVS_BYTEENABLE_I);

   always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         div_q      <= DIV_RST;
         subsel_q   <= 1'b0;
         mosc_q     <= 1'b0;
         stab_sel_q <= STAB_SEL_RST;
         pcfg_q     <= '0;
      end else if (CLK_EN_I) begin
         if (sync_rst) begin
            div_q      <= DIV_RST;
            subsel_q   <= 1'b0;
            mosc_q     <= 1'b0;
            stab_sel_q <= STAB_SEL_RST;
            pcfg_q     <= '0;
         end else if (do_wr && AVS_ADDRESS_I == CLK_CTRL_OFS) begin
            div_q    <= ctl_w[DIV_MSB:DIV_LSB];
            subsel_q <= ctl_w[SUBSEL_POS];
            mosc_q   <= ctl_w[MOSC_STOP_POS];
         end else if (do_wr && AVS_ADDRESS_I == STAB_SEL_OFS) begin
            stab_sel_q <= sel_w[STAB_SEL_W-1:0];
         end else if (do_wr && AVS_ADDRESS_I == PCFG_OFS) begin
            pcfg_q <= cfg_w[PCFG_W-1:0];
         end
      end
   end

   assign DIVIDER_SEL_O = div_q;

   // ************************************************
   // stop release and stabilization
   // ************************************************
   assign stab_load = sync_rst | (state_q == PS_STOP && WAKE_IRQ_I);
   // a reset restarts at the reset selection whatever software chose
   assign stab_len  = sync_rst ? RST_STAB : stab_cycles(stab_sel_q, CYC_PER_MAIN);

   smsw_stab_timer #(
      .RST_CYCLES (RST_STAB)
   ) u_stab (
      .clk_i    (SYS_CLK_I),
      .rst_i    (RESET_I),
      .en_i     (CLK_EN_I),
      .load_i   (stab_load),
      .cycles_i (stab_len),
      .busy_o   (busy)
   );

   always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         state_q <= PS_WAKE;
      end else if (CLK_EN_I) begin
         if (sync_rst) begin
            state_q <= PS_WAKE;
         end else begin
            unique case (state_q)
               PS_RUN:  if (STOP_REQ_I) state_q <= PS_STOP;
               PS_STOP: if (WAKE_IRQ_I) state_q <= PS_WAKE;
               PS_WAKE: if (!busy) state_q <= PS_RUN;
            endcase
         end
      end
   end

   assign CPU_CLK_EN_O = (state_q == PS_RUN);

   // ************************************************
   // system clock source
   // ************************************************
   smsw_clk_switch #(
      .GAP (SWITCH_GAP)
   ) u_switch (
      .clk_i      (SYS_CLK_I),
      .rst_i      (RESET_I),
      .en_i       (CLK_EN_I),
      .want_sub_i (subsel_q),
      .main_ok_i  (~mosc_q),
      .sel_main_o (on_main),
      .sel_sub_o  (on_sub)
   );

   assign SYS_CLK_SEL_MAIN_O = on_main;
   assign SYS_CLK_SEL_SUB_O  = on_sub;

   // stop bit only bites once the subclock really drives the system
   assign mosc_en_d = ~(mosc_q & on_sub) & (state_q != PS_STOP);

   always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         mosc_en_q <= 1'b1;
      end else if (CLK_EN_I) begin
         mosc_en_q <= mosc_en_d;
      end
   end

   assign MAIN_OSC_EN_O = mosc_en_q;

   // ************************************************
   // peripheral clock gating
   // ************************************************
   assign main_run = mosc_en_q & (state_q == PS_RUN);

   always_comb begin
      pen_d.tm16a = main_run;
      pen_d.tm16b = main_run | (pcfg_q.tm16b_watch & pcfg_q.watch_sub);
      pen_d.tm8   = {2{main_run}} | pcfg_q.tm8_ext | (pcfg_q.tm8_cmp & {2{pen_d.tm16b}});
      pen_d.itmr2 = main_run | pcfg_q.itmr2_sub;
      pen_d.watch = main_run | pcfg_q.watch_sub;
      pen_d.wdog2 = main_run | pcfg_q.wdog2_sub;
      pen_d.csi   = {2{main_run}} | pcfg_q.csi_ext;
      pen_d.async_port = main_run | pcfg_q.async_ext;
      pen_d.rto   = main_run | (pcfg_q.rto_tm8 & pcfg_q.tm8_ext[pcfg_q.rto_tm8_sel]);
   end

   always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         pen_q <= '0;
      end else if (CLK_EN_I) begin
         pen_q <= pen_d;
      end
   end

   assign PERIPH_CLK_EN_O = pen_q;

   // ************************************************
   // assertions
   // ************************************************
   default clocking cb @(posedge SYS_CLK_I); endclocking
   default disable iff (RESET_I);

   logic [31:0] wake_cnt_q;
   logic [31:0] wake_exp_q;

   always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         wake_cnt_q <= 32'h0;
         wake_exp_q <= RST_STAB;
      end else if (CLK_EN_I) begin
         if (stab_load) begin
            wake_cnt_q <= 32'h0;
            wake_exp_q <= stab_len;
         end else if (state_q == PS_WAKE) begin
            wake_cnt_q <= wake_cnt_q + 32'h1;
         end
      end
   end

   property p_wake_len;
      state_q == PS_WAKE && !busy |-> wake_cnt_q == wake_exp_q;
   endproperty
   a_wake_len: assert property (p_wake_len) else $error("wake hold length wrong");

   property p_irq_len;
      state_q == PS_STOP && WAKE_IRQ_I && CLK_EN_I && !sync_rst
         |=> wake_exp_q == stab_cycles(stab_sel_q, CYC_PER_MAIN);
   endproperty
   a_irq_len: assert property (p_irq_len) else $error("wake ignores selected wait");

   property p_rst_len;
      sync_rst && CLK_EN_I |=> state_q == PS_WAKE && wake_exp_q == RST_STAB && !CPU_CLK_EN_O;
   endproperty
   a_rst_len: assert property (p_rst_len) else $error("reset wake wait wrong");

   property p_to_sub;
      $rose(subsel_q) && CLK_EN_I |-> ##[1:24] on_sub;
   endproperty
   a_to_sub: assert property (p_to_sub) else $error("subclock mode not entered");

   property p_one_src;
      !(on_main && on_sub);
   endproperty
   a_one_src: assert property (p_one_src) else $error("both clock sources selected");

   property p_osc_off;
      mosc_q && on_sub && CLK_EN_I |=> !MAIN_OSC_EN_O;
   endproperty
   a_osc_off: assert property (p_osc_off) else $error("main oscillator still running");

   property p_wdog_exit;
      sync_rst && CLK_EN_I |=> !subsel_q;
   endproperty
   a_wdog_exit: assert property (p_wdog_exit) else $error("reset kept subclock mode");

   property p_to_main;
      $fell(subsel_q) && !mosc_q && CLK_EN_I |-> ##[1:24] on_main;
   endproperty
   a_to_main: assert property (p_to_main) else $error("normal mode not restored");

   property p_tm16;
      !main_run && CLK_EN_I |=> !PERIPH_CLK_EN_O.tm16a
         && (PERIPH_CLK_EN_O.tm16b == ($past(pcfg_q.tm16b_watch) && $past(pcfg_q.watch_sub)));
   endproperty
   a_tm16: assert property (p_tm16) else $error("16-bit timer gating wrong");

   property p_tm8;
      !main_run && !pcfg_q.tm8_ext[0] && !pcfg_q.tm8_cmp[0] && CLK_EN_I |=> !PERIPH_CLK_EN_O.tm8[0];
   endproperty
   a_tm8: assert property (p_tm8) else $error("8-bit timer runs without clock");

   property p_sub_users;
      !main_run && !pcfg_q.itmr2_sub && !pcfg_q.wdog2_sub && CLK_EN_I
         |=> !PERIPH_CLK_EN_O.itmr2 && !PERIPH_CLK_EN_O.wdog2;
   endproperty
   a_sub_users: assert property (p_sub_users) else $error("subclock user runs off main");

   property p_ser;
      !main_run && CLK_EN_I |=> PERIPH_CLK_EN_O.csi == $past(pcfg_q.csi_ext)
         && PERIPH_CLK_EN_O.async_port == $past(pcfg_q.async_ext);
   endproperty
   a_ser: assert property (p_ser) else $error("serial gating wrong");

   property p_rto;
      !main_run && !pcfg_q.rto_tm8 && CLK_EN_I |=> !PERIPH_CLK_EN_O.rto;
   endproperty
   a_rto: assert property (p_rto) else $error("real-time output runs without trigger");

   c_wake: cover property (state_q == PS_STOP ##1 state_q == PS_WAKE);
   c_sub: cover property ($rose(on_sub));
   c_osc_off: cover property ($fell(MAIN_OSC_EN_O) && on_sub);
   c_back: cover property ($rose(on_main));

endmodule // smsw_top

`default_nettype wire

// [smsw_osc_model.sv]
// main oscillator and clock mux model facing the block
// assumes enable and selects come straight from the block
`default_nettype none

module smsw_osc_model #(
   parameter int STAB_CYC = 64
) (
   // clock and reset
   input  wire logic  clk_i,
   input  wire logic  rst_i,
   // from the block
   input  wire logic  osc_en_i,
   input  wire logic  sel_main_i,
   input  wire logic  sel_sub_i,
   // status
   output logic       osc_stable_o,
   output logic [7:0] overlap_o
);
   timeunit 1ns;
   timeprecision 1ps;
   int run_q;

   // block never sees this; software has to time the restart
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i || !osc_en_i) run_q <= 0;
      else if (run_q < STAB_CYC) run_q <= run_q + 1;
   end
   assign osc_stable_o = osc_en_i && (run_q >= STAB_CYC);

   // both sources on the mux at once would chop a clock pulse
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) overlap_o <= 8'h00;
      else if (sel_main_i && sel_sub_i) overlap_o <= overlap_o + 8'h01;
   end
endmodule // smsw_osc_model

`default_nettype wire

// [subclock_mode_and_stop_wakeup_bench.sv]
// self-checking bench of the subclock mode and stop wakeup block
// assumes CYC_PER_MAIN of 1 so the reset wait is 32768 cycles
`default_nettype none

module subclock_mode_and_stop_wakeup_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import smsw_pkg::*;
   localparam int RST_WAIT = 32768;
   logic clk, rst, wd1, wd2, cen, stop_req, wake, rd, wr, wreq, wreq_smp, stable;
   logic [3:0] addr;
   logic [31:0] wdata, rdata, rdata_smp, q;
   logic [3:0] st, st_smp;
   logic [2:0] div;
   smsw_pen_t pen, pen_smp;
   smsw_pcfg_t cfg;
   logic [7:0] overlap;
   int error_cnt, num_checks, seed, n;

   smsw_top #(.CYC_PER_MAIN(32'h1), .SWITCH_GAP(SWITCH_GAP_CYC)) i_smsw_top (.SYS_CLK_I(clk), .RESET_I(rst),
      .CLK_EN_I(cen), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata),
      .AVS_BYTEENABLE_I(4'hf), .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(wreq), .WDOG1_RESET_I(wd1),
      .WDOG2_RESET_I(wd2), .STOP_REQ_I(stop_req), .WAKE_IRQ_I(wake), .MAIN_OSC_EN_O(st[3]),
      .SYS_CLK_SEL_MAIN_O(st[1]), .SYS_CLK_SEL_SUB_O(st[0]), .CPU_CLK_EN_O(st[2]), .DIVIDER_SEL_O(div),
      .PERIPH_CLK_EN_O(pen));
   smsw_osc_model i_smsw_osc_model (.clk_i(clk), .rst_i(rst), .osc_en_i(st[3]), .sel_main_i(st[1]),
      .sel_sub_i(st[0]), .osc_stable_o(stable), .overlap_o(overlap));

   // ************************************************
   // clock, samples, helpers
   // ************************************************
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // settled values before each rising edge, free of races
   always @(negedge clk) begin
      wreq_smp <= wreq;
      rdata_smp <= rdata;
      st_smp <= st;
      pen_smp <= pen;
   end

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask

   // waits for the answer however long it takes; only the watchdog ends a hang
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      rd <= !w;
      wr <= w;
      addr <= a;
      wdata <= d;
      do begin
         @(posedge clk);
      end while (wreq_smp !== 1'b0);
      q = rdata_smp;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask

   task automatic wait_bit(input int idx, input logic v, input int lim);
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (st_smp[idx] !== v && n < lim);
   endtask

   function automatic smsw_pen_t exp_pen(input smsw_pcfg_t c);
      smsw_pen_t p;
      p = '0;
      p.tm16b = c.tm16b_watch & c.watch_sub;
      p.tm8 = c.tm8_ext | (c.tm8_cmp & {2{p.tm16b}});
      p.itmr2 = c.itmr2_sub;
      p.watch = c.watch_sub;
      p.wdog2 = c.wdog2_sub;
      p.csi = c.csi_ext;
      p.async_port = c.async_ext;
      p.rto = c.rto_tm8 & c.tm8_ext[c.rto_tm8_sel];
      return p;
   endfunction

   task automatic conclude();
      if (error_cnt == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // ************************************************
   // sequence
   // ************************************************
   initial begin
      {rst, wd1, wd2, stop_req, wake, rd, wr} = 7'h40;
      cen = 1'b1;
      addr = 4'h0;
      wdata = 32'h0;
      error_cnt = 0;
      num_checks = 0;
      seed = 43176;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      wait_bit(2, 1'b1, RST_WAIT + 100);
      chk("reset wait", n, RST_WAIT + 2);
      bus(0, CLK_CTRL_OFS, 32'h0);
      chk("control reset", q, 32'h3);
      bus(0, STAB_SEL_OFS, 32'h0);
      chk("stab reset", q, 32'h2);
      bus(0, 4'h5, 32'h0);
      chk("unmapped", q, 32'h0);
      bus(1, CLK_CTRL_OFS, 32'hb);
      wait_bit(0, 1'b1, 50);
      chk("to sub cycles", n, 32'(SWITCH_GAP_CYC) + 3);
      chk("main off", 32'(st_smp[1]), 32'h0);
      bus(1, CLK_CTRL_OFS, 32'h4b);
      repeat (3) @(posedge clk);
      chk("osc off", 32'(st_smp[3]), 32'h0);
      for (int k = 0; k < 8; k++) begin
         cfg = (k == 0) ? smsw_pcfg_t'(13'h1383) : smsw_pcfg_t'(13'($random(seed)));
         bus(1, PCFG_OFS, 32'(cfg));
         bus(0, PCFG_OFS, 32'h0);
         chk("config", q, 32'(cfg));
         repeat (3) @(posedge clk);
         chk("gating", 32'(pen_smp), 32'(exp_pen(cfg)));
      end
      // clearing the select with the oscillator off must not leave the subclock
      bus(1, CLK_CTRL_OFS, 32'h43);
      repeat (10) @(posedge clk);
      chk("held on sub", 32'(st_smp[1:0]), 32'h1);
      bus(1, CLK_CTRL_OFS, 32'hb);
      n = 0;
      while (stable !== 1'b1 && n < 1000) begin
         @(posedge clk);
         n++;
      end
      bus(1, CLK_CTRL_OFS, 32'h3);
      wait_bit(1, 1'b1, 50);
      chk("to main cycles", n, 32'(SWITCH_GAP_CYC) + 3);
      chk("sub off", 32'(st_smp[0]), 32'h0);
      chk("divider", 32'(div), 32'h3);
      repeat (3) @(posedge clk);
      chk("all enabled", 32'(pen_smp), 32'h7ff);
      bus(1, STAB_SEL_OFS, 32'h0);
      stop_req <= 1'b1;
      @(posedge clk);
      stop_req <= 1'b0;
      repeat (3) @(posedge clk);
      chk("stopped", 32'(st_smp[2]), 32'h0);
      wake <= 1'b1;
      @(posedge clk);
      wake <= 1'b0;
      // frozen edges must not count towards the wait
      cen <= 1'b0;
      repeat (6) @(posedge clk);
      cen <= 1'b1;
      wait_bit(2, 1'b1, 9000);
      chk("wake wait", n, (32'h1 << STAB_EXP_BASE) + 32'h2);
      bus(1, CLK_CTRL_OFS, 32'hb);
      wait_bit(0, 1'b1, 50);
      chk("sub before watchdog", n, 32'(SWITCH_GAP_CYC) + 3);
      wd1 <= 1'b1;
      @(posedge clk);
      wd1 <= 1'b0;
      wait_bit(1, 1'b1, 50);
      chk("watchdog exit cycles", n, 32'(SWITCH_GAP_CYC) + 3);
      chk("watchdog exit", 32'(st_smp[1:0]), 32'h2);
      bus(0, CLK_CTRL_OFS, 32'h0);
      chk("select cleared", q, 32'h3);
      // second watchdog restarts the pending wait from its full length
      bus(1, CLK_CTRL_OFS, 32'hb);
      wait_bit(0, 1'b1, 50);
      wd2 <= 1'b1;
      @(posedge clk);
      wd2 <= 1'b0;
      wait_bit(2, 1'b1, RST_WAIT + 100);
      chk("watchdog wait", n, RST_WAIT + 2);
      chk("second watchdog exit", 32'(st_smp[1:0]), 32'h2);
      bus(0, CLK_CTRL_OFS, 32'h0);
      chk("second select cleared", q, 32'h3);
      chk("overlap", 32'(overlap), 32'h0);
      conclude();
   end

   initial begin
      #450000;
      error_cnt++;
      conclude();
   end
endmodule // subclock_mode_and_stop_wakeup_bench

`default_nettype wire
